//--- design/cmro_core.sv
`timescale 1ns/100ps
module cmro_core
  import cmro_pkg::*;
(
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  // instruction in
  input  wire logic        I_VALID,
  input  wire logic [13:0] I_OPCODE,
  input  wire logic [7:0]  I_ACCUM,
  input  wire logic [12:0] I_STACK_TOP,
  // file register and option port
  output logic             O_FILE_WE,
  output logic [6:0]       O_FILE_ADDR,
  output logic [7:0]       O_FILE_DATA,
  output logic             O_OPTION_WE,
  output logic [7:0]       O_OPTION_DATA,
  // stack, pc and interrupt control
  output logic             O_STACK_POP,
  output logic             O_PC_LOAD,
  output logic [12:0]      O_PC_VALUE,
  output logic             O_IRQ_EN_SET,
  output logic             O_FLUSH,
  output logic             O_NOP
);
  cmro_op_t  op;
  cmro_out_t st;
  cmro_out_t next_st;
  logic      taken;

  cmro_decode u_dec
  (
    .i_opcode (I_OPCODE),
    .o_op     (op)
  );

  // the slot after a return is the discarded fetch: nothing issues there
  assign taken = I_VALID && !st.flush;

  always_comb
  begin
    next_st = '0;
    if (taken)
    begin
      case (op)
        CMRO_STORE:
        begin
          next_st.file_we   = 1'b1;
          next_st.file_addr = I_OPCODE[ADDR_W-1:0];
          next_st.file_data = I_ACCUM;
        end
        CMRO_IRET:
        begin
          next_st.pop      = 1'b1;
          next_st.pc_load  = 1'b1;
          next_st.pc_value = I_STACK_TOP;
          next_st.irq_en_set = 1'b1;
          next_st.flush    = 1'b1;
        end
        CMRO_OPTION:
        begin
          next_st.option_we   = 1'b1;
          next_st.option_data = I_ACCUM;
        end
        CMRO_NOP:   next_st.nop = 1'b1;
        default:    next_st = '0;
      endcase
    end
  end

  // one register stage for every output, so strobes and their data move together
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      st <= '0;
    else
      st <= next_st;
  end

  assign O_FILE_WE     = st.file_we;
  assign O_FILE_ADDR   = st.file_addr;
  assign O_FILE_DATA   = st.file_data;
  assign O_OPTION_WE   = st.option_we;
  assign O_OPTION_DATA = st.option_data;
  assign O_STACK_POP   = st.pop;
  assign O_PC_LOAD     = st.pc_load;
  assign O_PC_VALUE    = st.pc_value;
  assign O_IRQ_EN_SET  = st.irq_en_set;
  assign O_FLUSH       = st.flush;
  assign O_NOP         = st.nop;

  // the checks decode on their own, so a decoder fault cannot hide behind them
  function automatic logic is_store(input logic [13:0] w);
    return (w & STORE_MASK) == STORE_MATCH;
  endfunction

  function automatic logic is_iret(input logic [13:0] w);
    return w == IRET_OPC;
  endfunction

  function automatic logic is_option(input logic [13:0] w);
    return w == OPTION_OPC;
  endfunction

  function automatic logic is_nop(input logic [13:0] w);
    return (w & NOP_MASK) == NOP_MATCH;
  endfunction

  function automatic logic is_known(input logic [13:0] w);
    return is_store(w) || is_iret(w) || is_option(w) || is_nop(w);
  endfunction

  sequence s_store_in;
    taken && is_store(I_OPCODE);
  endsequence

  sequence s_iret_in;
    taken && is_iret(I_OPCODE);
  endsequence

  sequence s_option_in;
    taken && is_option(I_OPCODE);
  endsequence

  sequence s_nop_in;
    taken && is_nop(I_OPCODE);
  endsequence

  sequence s_iret_out;
    O_STACK_POP && O_PC_LOAD && O_IRQ_EN_SET && O_FLUSH;
  endsequence

  // no strobe other than O_FLUSH in this slot; flush is checked separately
  sequence s_slot_quiet;
    !O_FILE_WE && !O_OPTION_WE && !O_STACK_POP && !O_PC_LOAD && !O_IRQ_EN_SET && !O_NOP;
  endsequence

  a_store_write: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_store_in
    |=> O_FILE_WE && O_FILE_ADDR == $past(I_OPCODE[6:0]) && O_FILE_DATA == $past(I_ACCUM))
    else $error("store did not write file register");

  a_store_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !O_FILE_WE |-> O_FILE_ADDR == ADDR_RST && O_FILE_DATA == DATA_RST)
    else $error("file port data without write strobe");

  a_one_action: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FILE_WE |-> !O_OPTION_WE && !O_PC_LOAD && !O_NOP)
    else $error("store overlapped another action");

  a_iret_decode: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_STACK_POP |-> $past(I_OPCODE) == IRET_OPC && !O_FILE_WE && !O_OPTION_WE)
    else $error("pop without return opcode");

  a_iret_pc: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_iret_in |=> s_iret_out and (O_PC_VALUE == $past(I_STACK_TOP)))
    else $error("return did not load stack top");

  a_pc_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !O_PC_LOAD |-> O_PC_VALUE == PC_RST && !O_STACK_POP)
    else $error("pc value or pop without pc load");

  a_pop_pairs: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_PC_LOAD |-> O_STACK_POP && O_FLUSH)
    else $error("pc load without pop and flush");

  a_irq_enable: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_IRQ_EN_SET |-> O_PC_LOAD && O_STACK_POP)
    else $error("enable set outside return");

  a_irq_on_iret: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_iret_in |=> O_IRQ_EN_SET)
    else $error("return did not set interrupt enable");

  a_iret_two: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_iret_in ##1 s_iret_out |=> s_slot_quiet and !O_FLUSH)
    else $error("fetch after return not discarded");

  a_flush_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FLUSH |=> !O_FLUSH)
    else $error("flush held for more than one slot");

  a_flush_cause: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FLUSH |-> $past(taken) && is_iret($past(I_OPCODE)))
    else $error("flush without a taken return");

  a_drop_store: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_iret_in ##1 (I_VALID && is_store(I_OPCODE)) |=> !O_FILE_WE)
    else $error("store in discarded slot was executed");

  a_resume_slot: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_iret_in ##2 s_store_in |=> O_FILE_WE)
    else $error("slot after the discarded fetch was lost");

  a_option_load: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_option_in
    |=> O_OPTION_WE && O_OPTION_DATA == $past(I_ACCUM) && !O_FILE_WE)
    else $error("option load missing");

  a_option_idle: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !O_OPTION_WE |-> O_OPTION_DATA == DATA_RST)
    else $error("option data without write strobe");

  a_option_alone: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_OPTION_WE |-> !O_PC_LOAD && !O_NOP && !O_STACK_POP)
    else $error("option load overlapped another action");

  a_nop_exec: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_nop_in
    |=> O_NOP && !O_FILE_WE && !O_OPTION_WE && !O_PC_LOAD)
    else $error("nop opcode not executed as nop");

  a_nop_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_NOP |-> !O_FILE_WE && !O_OPTION_WE && !O_PC_LOAD && !O_IRQ_EN_SET && !O_STACK_POP)
    else $error("nop changed state");

  a_other_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (taken && !is_known(I_OPCODE)) |=> s_slot_quiet and !O_FLUSH)
    else $error("unknown opcode caused an action");

  a_idle_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !I_VALID |=> s_slot_quiet and !O_FLUSH)
    else $error("action without a valid instruction");
endmodule

//--- design/cmro_decode.sv
`timescale 1ns/100ps
module cmro_decode
  import cmro_pkg::*;
(
  // opcode in
  input  wire logic [13:0] i_opcode,
  // class out
  output cmro_op_t         o_op
);
  always_comb
  begin
    if ((i_opcode & STORE_MASK) == STORE_MATCH)
      o_op = CMRO_STORE;
    else if (i_opcode == IRET_OPC)
      o_op = CMRO_IRET;
    else if (i_opcode == OPTION_OPC)
      o_op = CMRO_OPTION;
    else if ((i_opcode & NOP_MASK) == NOP_MATCH)
      o_op = CMRO_NOP;
    else
      o_op = CMRO_OTHER;
  end
endmodule

//--- design/cmro_pkg.sv
// Notes on behaviour
// - opcode 00 0000 1fff ffff copies accumulator to file register f, one cycle.
// - opcode 00 0000 0000 1001 is return from interrupt, one word, no flags.
// - return from interrupt pops the stack and loads the top entry into the PC.
// - return from interrupt sets interrupt control register bit 7 to one.
// - return from interrupt takes two cycles; the following fetch is discarded.
// - opcode 00 0000 0110 0010 copies accumulator to option register, one cycle.
package cmro_pkg;
  localparam int         OPC_W           = 14;
  localparam int         ADDR_W          = 7;
  localparam int         DATA_W          = 8;
  localparam int         PC_W            = 13;
  localparam int         IRQ_EN_POS      = 7;
  localparam logic [13:0] STORE_MASK     = 14'h3f80;
  localparam logic [13:0] STORE_MATCH    = 14'h0080;
  localparam logic [13:0] IRET_OPC       = 14'h0009;
  localparam logic [13:0] OPTION_OPC     = 14'h0062;
  localparam logic [13:0] NOP_MASK       = 14'h3f9f;
  localparam logic [13:0] NOP_MATCH      = 14'h0000;
  localparam logic [6:0]  ADDR_RST       = 7'h00;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [12:0] PC_RST         = 13'h0000;

  typedef enum logic [2:0]
  {
    CMRO_OTHER  = 3'b000,
    CMRO_STORE  = 3'b001,
    CMRO_IRET   = 3'b010,
    CMRO_OPTION = 3'b011,
    CMRO_NOP    = 3'b100
  } cmro_op_t;

  typedef struct packed
  {
    logic        file_we;
    logic [6:0]  file_addr;
    logic [7:0]  file_data;
    logic        option_we;
    logic [7:0]  option_data;
    logic        pop;
    logic        pc_load;
    logic [12:0] pc_value;
    logic        irq_en_set;
    logic        flush;
    logic        nop;
  } cmro_out_t;
endpackage

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench
  import cmro_pkg::*;
;
  logic             I_SYS_CLK = 1'b0;
  logic             I_RST = 1'b1;
  logic             i_valid = 1'b0;
  logic [13:0]      i_opcode = 14'h0000;
  logic [7:0]       i_accum = 8'h00;
  logic [12:0]      i_stack_top = 13'h0000;
  logic             O_FILE_WE, O_OPTION_WE, O_STACK_POP, O_PC_LOAD, O_IRQ_EN_SET, O_FLUSH, O_NOP;
  logic [6:0]       O_FILE_ADDR;
  logic [7:0]       O_FILE_DATA, O_OPTION_DATA;
  logic [12:0]      O_PC_VALUE;
  cmro_out_t        got, want;
  int               err_count = 0;
  int               n_compared = 0;
  logic [31:0]      lfsr = 32'hc124;
  logic [13:0]      corner [12] = '{IRET_OPC, IRET_OPC, 14'h00ff, 14'h0080, OPTION_OPC,
    14'h0060, 14'h0061, IRET_OPC, OPTION_OPC, 14'h0020, 14'h0040, 14'h0000};

  always #2 I_SYS_CLK = ~I_SYS_CLK;
  assign got = {O_FILE_WE, O_FILE_ADDR, O_FILE_DATA, O_OPTION_WE, O_OPTION_DATA, O_STACK_POP,
    O_PC_LOAD, O_PC_VALUE, O_IRQ_EN_SET, O_FLUSH, O_NOP};

  cmro_core i_dut (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_VALID(i_valid),
    .I_OPCODE(i_opcode), .I_ACCUM(i_accum), .I_STACK_TOP(i_stack_top),
    .O_FILE_WE(O_FILE_WE), .O_FILE_ADDR(O_FILE_ADDR), .O_FILE_DATA(O_FILE_DATA),
    .O_OPTION_WE(O_OPTION_WE), .O_OPTION_DATA(O_OPTION_DATA), .O_STACK_POP(O_STACK_POP),
    .O_PC_LOAD(O_PC_LOAD), .O_PC_VALUE(O_PC_VALUE), .O_IRQ_EN_SET(O_IRQ_EN_SET),
    .O_FLUSH(O_FLUSH), .O_NOP(O_NOP));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  // slot after a return is dropped, so the model needs the flush it predicted
  function automatic cmro_out_t model(input logic v, input logic [13:0] op,
    input logic [7:0] acc, input logic [12:0] top, input logic fl);
    cmro_out_t o;
    o = '0;
    if (v && !fl)
    begin
      if ((op & STORE_MASK) == STORE_MATCH)
        {o.file_we, o.file_addr, o.file_data} = {1'b1, op[6:0], acc};
      else if (op == IRET_OPC)
        {o.pop, o.pc_load, o.pc_value, o.irq_en_set, o.flush} = {2'b11, top, 2'b11};
      else if (op == OPTION_OPC)
        {o.option_we, o.option_data} = {1'b1, acc};
      else if ((op & NOP_MASK) == NOP_MATCH)
        o.nop = 1'b1;
    end
    return o;
  endfunction

  task automatic check(input logic [42:0] seen, input logic [42:0] exp_v);
    n_compared++;
    if (seen !== exp_v)
    begin
      err_count++;
      $display("BAD t=%0t got %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic step(input logic v, input logic [13:0] op);
    @(posedge I_SYS_CLK);
    want = model(i_valid, i_opcode, i_accum, i_stack_top, want.flush);
    lfsr = lfsr_next(lfsr);
    i_valid <= v;
    i_opcode <= op;
    i_accum <= lfsr[7:0];
    i_stack_top <= lfsr[20:8];
    @(negedge I_SYS_CLK);
    check(43'({got.file_we, got.file_addr, got.file_data}), 43'({want.file_we, want.file_addr, want.file_data}));
    check(43'({got.pop, got.pc_load, got.pc_value}), 43'({want.pop, want.pc_load, want.pc_value}));
    check(43'(got.irq_en_set), 43'(want.irq_en_set));
    check(43'(got.flush), 43'(want.flush));
    check(43'({got.option_we, got.option_data}), 43'({want.option_we, want.option_data}));
    check(43'(got.nop), 43'(want.nop));
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    want = '0;
    repeat (20) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    foreach (corner[k])
      step(1'b1, corner[k]);
    $display("corner cases done");
    // reset lands on the edge that takes a return; no part of it may survive
    step(1'b1, IRET_OPC);
    @(posedge I_SYS_CLK);
    I_RST <= 1'b1;
    i_valid <= 1'b0;
    want = '0;
    @(negedge I_SYS_CLK);
    check(43'(got), 43'(want));
    repeat (2) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    $display("mid-run reset done");
    repeat (3000)
    begin
      case (lfsr[26:24])
        3'd0, 3'd1: step(lfsr[29], STORE_MATCH | 14'(lfsr[6:0]));
        3'd2: step(lfsr[29], IRET_OPC);
        3'd3: step(lfsr[29], OPTION_OPC);
        3'd4: step(lfsr[29], 14'({lfsr[6:5], 5'h00}));
        default: step(lfsr[29], lfsr[13:0]);
      endcase
    end
    $display("random traffic done");
    stop_test();
  end
endmodule
